// >>> logic/rpi_pkg.sv
// Shared constants for the pipeline interlock block.
// Assumes a 64-entry register file (two banks of 32) and one processor clock.
package rpi_pkg;
    localparam int          REG_COUNT      = 64;
    localparam int          REG_AW         = 6;
    localparam int          DIV_MAX_TICKS  = 16;
    localparam int          JUMP_WAIT      = 3;
    localparam int          IDX_STORE_WAIT = 1;
    localparam int          INT_MEM_SLOTS  = 1;
    localparam int          EXT_MEM_SLOTS  = 2;
    localparam logic [1:0]  WAIT_W0        = 2'h0;
    localparam logic [1:0]  JUMP_WAIT_V    = 2'h3;
    localparam logic [1:0]  SLOT_ZERO      = 2'h0;
    localparam logic [1:0]  SLOT_ONE       = 2'h1;
    localparam logic [1:0]  SLOT_TWO       = 2'h2;
    typedef enum logic [1:0] {RPI_RUN, RPI_WAIT} rpi_state_e;
endpackage

// >>> logic/rpi_pending.sv
// Per-register pending flags for results and loads still outstanding.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
module rpi_pending
    import rpi_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              set_en,
    input  wire logic [REG_AW-1:0] set_idx,
    input  wire logic              clr_en,
    input  wire logic [REG_AW-1:0] clr_idx,
    input  wire logic              clr2_en,
    input  wire logic [REG_AW-1:0] clr2_idx,
    output logic [REG_COUNT-1:0]   pend_r
);
    logic [REG_COUNT-1:0] pend_nxt;
    always_comb begin
        pend_nxt = pend_r;
        if (clr_en) begin
            pend_nxt[clr_idx] = 1'b0;
        end
        // Load and divide may finish together; neither clear may be lost
        if (clr2_en) begin
            pend_nxt[clr2_idx] = 1'b0;
        end
        // Set wins over a clear in the same tick
        if (set_en) begin
            pend_nxt[set_idx] = 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_r <= '0;
        end else begin
            pend_r <= pend_nxt;
        end
    end
endmodule

// >>> logic/rpi_interlock.sv
// Contract
// - No hazard means one instruction issues every tick.
// - Reading the previous instruction's destination costs one wait tick.
// - Using flags from the previous instruction costs one wait tick.
// - Pending write-back with no operand match stalls one tick.
// - Two write-backs in one tick insert one wait tick.
// - Using a divide result stalls until the divider finishes.
// - A new divide waits while the previous divide is busy.
// - Reading a register awaiting load data stalls until data arrives.
// - One internal or two external transfers may pend; more stall.
// - An indexed store is followed by one wait tick.
// - Jumps from internal memory are followed by three wait ticks.
// - Issue stalls until the next instruction has been fetched.
// - Host access to local space stalls a running matrix multiply.
//
// Issue-stage interlock: decides each tick whether the decoded instruction issues.
// Assumes decode, divider, memory interface and fetch are on the same clock.
`timescale 1ns/100ps
module rpi_interlock
    import rpi_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              inst_valid,
    input  wire logic              rd_src_en,
    input  wire logic [REG_AW-1:0] rd_src,
    input  wire logic              rd_dst_en,
    input  wire logic [REG_AW-1:0] rd_dst,
    input  wire logic              wr_dst_en,
    input  wire logic [REG_AW-1:0] wr_dst,
    input  wire logic              uses_flags,
    input  wire logic              sets_flags,
    input  wire logic              is_divide,
    input  wire logic              is_load,
    input  wire logic              is_store,
    input  wire logic              is_indexed,
    input  wire logic              is_jump,
    input  wire logic              is_external,
    input  wire logic              exec_internal,
    input  wire logic              fetch_ready,
    input  wire logic              div_busy,
    input  wire logic              div_done,
    input  wire logic [REG_AW-1:0] div_dst,
    input  wire logic              load_done,
    input  wire logic [REG_AW-1:0] load_dst,
    input  wire logic              mem_done,
    input  wire logic              wb_pending,
    input  wire logic              wb_dual,
    input  wire logic              mmult_active,
    input  wire logic              host_local_access,
    output logic                   issue_r,
    output logic                   stall_r,
    output logic                   mmult_wait_r
);
    rpi_state_e state_r;
    rpi_state_e state_nxt;
    logic [1:0]            wait_r;
    logic [1:0]            wait_nxt;
    logic [1:0]            slots_r;
    logic [1:0]            slots_nxt;
    logic                  prev_wr_r;
    logic [REG_AW-1:0]     prev_dst_r;
    logic                  prev_flags_r;
    logic                  div_owed_r;
    logic [REG_COUNT-1:0]  pend;

    function automatic logic hit(input logic en, input logic [REG_AW-1:0] a,
                                 input logic pv, input logic [REG_AW-1:0] b);
        return en && pv && (a == b);
    endfunction

    wire issue_now;
    wire pend_set = issue_now && ((is_load && wr_dst_en) || (is_divide && wr_dst_en));

    rpi_pending u_pend (
        .clock   (clock),
        .rst     (rst),
        .set_en  (pend_set),
        .set_idx (wr_dst),
        .clr_en  (load_done),
        .clr_idx (load_dst),
        .clr2_en (div_done),
        .clr2_idx(div_dst),
        .pend_r  (pend)
    );

    wire prev_valid = issue_r;
    wire haz_raw   = prev_valid && (hit(rd_src_en, rd_src, prev_wr_r, prev_dst_r) ||
                     hit(rd_dst_en, rd_dst, prev_wr_r, prev_dst_r));
    wire haz_flag  = prev_valid && uses_flags && prev_flags_r;
    wire op_match  = hit(rd_src_en, rd_src, prev_wr_r, prev_dst_r) || hit(rd_dst_en, rd_dst, prev_wr_r, prev_dst_r);
    wire haz_wb    = wb_pending && !op_match && (rd_src_en || rd_dst_en);
    wire haz_dual  = wb_dual;
    // Data arriving this tick is forwarded, so an internal load costs one tick only
    wire free_src  = hit(rd_src_en, rd_src, load_done, load_dst) || hit(rd_src_en, rd_src, div_done, div_dst);
    wire free_dst  = hit(rd_dst_en, rd_dst, load_done, load_dst) || hit(rd_dst_en, rd_dst, div_done, div_dst);
    wire pend_src  = rd_src_en && pend[rd_src] && !free_src;
    wire pend_dst  = rd_dst_en && pend[rd_dst] && !free_dst;
    wire haz_pend  = pend_src || pend_dst;
    wire haz_div   = haz_pend && div_owed_r;
    wire haz_divb  = is_divide && div_busy;
    wire haz_load  = haz_pend;
    wire [1:0] slot_cap = is_external ? SLOT_TWO : SLOT_ONE;
    wire haz_mem   = (is_load || is_store) && (slots_r >= slot_cap);
    wire haz_fetch = !fetch_ready;
    wire haz_wait  = (state_r == RPI_WAIT);
    wire any_haz   = haz_raw || haz_flag || haz_wb || haz_dual || haz_div || haz_divb ||
                     haz_load || haz_mem || haz_fetch || haz_wait;
    assign issue_now = inst_valid && !any_haz;

    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        unique case (state_r)
            RPI_RUN: begin
                if (issue_now && is_jump && exec_internal) begin
                    state_nxt = RPI_WAIT;
                    wait_nxt  = JUMP_WAIT_V;
                end else if (issue_now && is_store && is_indexed) begin
                    state_nxt = RPI_WAIT;
                    wait_nxt  = SLOT_ONE;
                end
            end
            RPI_WAIT: begin
                wait_nxt = wait_r - SLOT_ONE;
                if (wait_r == SLOT_ONE) begin
                    state_nxt = RPI_RUN;
                end
            end
        endcase
    end

    always_comb begin
        slots_nxt = slots_r;
        if (issue_now && (is_load || is_store) && !mem_done) begin
            slots_nxt = slots_r + SLOT_ONE;
        end else if (!(issue_now && (is_load || is_store)) && mem_done && slots_r != SLOT_ZERO) begin
            slots_nxt = slots_r - SLOT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r      <= RPI_RUN;
            wait_r       <= WAIT_W0;
            slots_r      <= SLOT_ZERO;
            issue_r      <= 1'b0;
            stall_r      <= 1'b0;
            mmult_wait_r <= 1'b0;
            prev_wr_r    <= 1'b0;
            prev_dst_r   <= '0;
            prev_flags_r <= 1'b0;
            div_owed_r   <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            wait_r       <= wait_nxt;
            slots_r      <= slots_nxt;
            issue_r      <= issue_now;
            stall_r      <= inst_valid && any_haz;
            mmult_wait_r <= mmult_active && host_local_access;
            if (issue_now) begin
                prev_wr_r    <= wr_dst_en && !is_load && !is_divide;
                prev_dst_r   <= wr_dst;
                prev_flags_r <= sets_flags;
            end
            if (issue_now && is_divide) begin
                div_owed_r <= 1'b1;
            end else if (div_done) begin
                div_owed_r <= 1'b0;
            end
        end
    end

    a_idle_issue: assert property (@(posedge clock) disable iff (rst)
        inst_valid && !any_haz |=> issue_r) else $error("issue missed with no hazard");
    a_raw_wait: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_raw |=> !issue_r) else $error("raw hazard issued");
    a_flag_wait: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_flag |=> !issue_r) else $error("flag hazard issued");
    a_dual_wb: assert property (@(posedge clock) disable iff (rst)
        inst_valid && wb_dual |=> stall_r) else $error("dual write-back not stalled");
    a_div_busy: assert property (@(posedge clock) disable iff (rst)
        inst_valid && is_divide && div_busy |=> !issue_r) else $error("divide issued while busy");
    a_pend_read: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_pend |=> !issue_r) else $error("pending register read issued");
    sequence s_jump_int;
        issue_now && is_jump && exec_internal && state_r == RPI_RUN;
    endsequence
    a_jump_gap: assert property (@(posedge clock) disable iff (rst)
        s_jump_int |=> (state_r == RPI_WAIT) [*3] ##1 state_r == RPI_RUN) else $error("jump gap wrong");
    a_idx_gap: assert property (@(posedge clock) disable iff (rst)
        issue_now && is_store && is_indexed && !is_jump && state_r == RPI_RUN
        |=> state_r == RPI_WAIT ##1 state_r == RPI_RUN) else $error("indexed store gap wrong");
    a_fetch_wait: assert property (@(posedge clock) disable iff (rst)
        !fetch_ready |=> !issue_r) else $error("issued without fetch");
    a_mem_cap: assert property (@(posedge clock) disable iff (rst)
        slots_r <= SLOT_TWO) else $error("memory slots overflow");

    // Issue follows only from a valid instruction
    a_no_valid: assert property (@(posedge clock) disable iff (rst)
        !inst_valid |=> !issue_r) else $error("issue without a valid instruction");
    a_stall_flag: assert property (@(posedge clock) disable iff (rst)
        inst_valid && any_haz |=> stall_r && !issue_r) else $error("hazard not reported as stall");

    // Back-to-back pairs built from the issue of the earlier instruction
    sequence s_raw_pair;
        issue_now && wr_dst_en && !is_load && !is_divide ##1 inst_valid && rd_src_en && rd_src == prev_dst_r;
    endsequence
    sequence s_flag_pair;
        issue_now && sets_flags ##1 inst_valid && uses_flags;
    endsequence
    a_raw_once: assert property (@(posedge clock) disable iff (rst)
        s_raw_pair |=> !issue_r) else $error("dependent read issued back to back");
    a_flag_once: assert property (@(posedge clock) disable iff (rst)
        s_flag_pair |=> !issue_r) else $error("flag user issued back to back");

    a_wb_wait: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_wb |=> !issue_r) else $error("write-back conflict issued");
    a_wb_stall: assert property (@(posedge clock) disable iff (rst)
        inst_valid && wb_pending && !op_match && rd_src_en |=> stall_r) else $error("write-back stall missing");

    a_dual_wait: assert property (@(posedge clock) disable iff (rst)
        inst_valid && wb_dual |=> !issue_r) else $error("dual write-back issued");

    a_div_wait: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_div |=> !issue_r) else $error("divide result used early");
    a_div_owed: assert property (@(posedge clock) disable iff (rst)
        issue_now && is_divide |=> div_owed_r) else $error("divide not tracked");

    a_busy_stall: assert property (@(posedge clock) disable iff (rst)
        inst_valid && is_divide && div_busy |=> stall_r) else $error("busy divider not stalled");

    a_load_wait: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_load |=> stall_r) else $error("load wait not stalled");

    a_mem_full: assert property (@(posedge clock) disable iff (rst)
        inst_valid && (is_load || is_store) && slots_r >= slot_cap |=> !issue_r) else $error("transfer past capacity");
    a_mem_count: assert property (@(posedge clock) disable iff (rst)
        issue_now && (is_load || is_store) && !mem_done && slots_r == SLOT_ZERO |=> slots_r == SLOT_ONE)
        else $error("transfer not counted");
    a_slot_drain: assert property (@(posedge clock) disable iff (rst)
        mem_done && !(issue_now && (is_load || is_store)) && slots_r == SLOT_ONE |=> slots_r == SLOT_ZERO)
        else $error("finished transfer not released");

    // Wait ticks after jumps and indexed stores
    a_wait_block: assert property (@(posedge clock) disable iff (rst)
        inst_valid && state_r == RPI_WAIT |=> !issue_r) else $error("issued in a wait tick");
    a_wait_stall: assert property (@(posedge clock) disable iff (rst)
        inst_valid && haz_wait |=> stall_r) else $error("wait tick not stalled");
    a_jump_hold: assert property (@(posedge clock) disable iff (rst)
        s_jump_int |=> ##1 (!issue_r) [*3]) else $error("issue inside jump gap");
    a_idx_hold: assert property (@(posedge clock) disable iff (rst)
        issue_now && is_store && is_indexed && !is_jump && state_r == RPI_RUN |=> ##1 !issue_r)
        else $error("issue inside indexed store gap");
    a_wait_count: assert property (@(posedge clock) disable iff (rst)
        state_r == RPI_WAIT |-> wait_r != WAIT_W0) else $error("wait state with empty count");

    a_fetch_stall: assert property (@(posedge clock) disable iff (rst)
        inst_valid && !fetch_ready |=> stall_r) else $error("missing fetch not stalled");

    a_mmult_wait: assert property (@(posedge clock) disable iff (rst)
        mmult_active && host_local_access |=> mmult_wait_r) else $error("multiply wait missing");
    a_mmult_idle: assert property (@(posedge clock) disable iff (rst)
        !mmult_active |=> !mmult_wait_r) else $error("multiply wait without multiply");

    // Pending flags follow issue and arrival
    a_pend_set: assert property (@(posedge clock) disable iff (rst)
        issue_now && is_load && wr_dst_en |=> pend[$past(wr_dst)]) else $error("load not marked pending");
    a_pend_clear: assert property (@(posedge clock) disable iff (rst)
        load_done && !(pend_set && wr_dst == load_dst) |=> !pend[$past(load_dst)])
        else $error("arrived load still pending");
endmodule

// >>> test/rpi_far.sv
// Far-side model: divider and memory transfer pipe.
// Assumes issue_r flags the instruction held at the prior edge.
`timescale 1ns/100ps
module rpi_far
    import rpi_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              issue_r,
    input  wire logic              is_divide,
    input  wire logic              is_load,
    input  wire logic              is_store,
    input  wire logic [REG_AW-1:0] wr_dst,
    input  wire logic [4:0]        div_len,
    input  wire logic [3:0]        mem_lat,
    output logic                   div_busy,
    output logic                   div_done,
    output logic [REG_AW-1:0]      div_dst,
    output logic                   load_done,
    output logic [REG_AW-1:0]      load_dst,
    output logic                   mem_done
);
    logic              l_dv = 1'b0, l_ld = 1'b0, l_st = 1'b0, tg = 1'b0;
    logic [REG_AW-1:0] l_dst = '0, d_dst = '0, md [16];
    logic [15:0]       mv = 16'h0, ml = 16'h0;
    logic [4:0]        dcnt = 5'h0;
    // Busy from the issue edge, so a second divide sees it at once
    assign div_busy = (dcnt > 5'h1) | (issue_r & l_dv);
    assign div_done = dcnt == 5'h1;
    assign mem_done = mv[0];
    assign load_done = mv[0] & ml[0];
    // Idle result buses toggle, so a stale value never looks valid
    assign div_dst = div_done ? d_dst : {REG_AW{tg}};
    assign load_dst = mv[0] ? md[0] : {REG_AW{tg}};
    always @(posedge clock) begin
        {l_dv, l_ld, l_st, l_dst, tg} <= {is_divide, is_load, is_store, wr_dst, ~tg};
        dcnt <= (issue_r & l_dv) ? div_len : dcnt - 5'(dcnt != 5'h0);
        d_dst <= (issue_r & l_dv) ? l_dst : d_dst;
        mv <= mv >> 1;
        ml <= ml >> 1;
        for (int i = 0; i < 15; i++) md[i] <= md[i + 1];
        if (issue_r & (l_ld | l_st)) begin
            mv[mem_lat - 4'h1] <= 1'b1;
            ml[mem_lat - 4'h1] <= l_ld;
            md[mem_lat - 4'h1] <= l_dst;
        end
    end
endmodule

// >>> test/risc_pipeline_interlock_bench.sv
// Bench: random and corner instruction streams through the interlock.
// Assumes rpi_far for divider and memory; fetch is driven here.
`timescale 1ns/100ps
module risc_pipeline_interlock_bench;
    import rpi_pkg::*;
    localparam logic [9:0] UF = 10'h200, SF = 10'h100, DV = 10'h080, LD = 10'h040, ST = 10'h020;
    localparam logic [9:0] IX = 10'h010, JP = 10'h008, EX = 10'h004, RS = 10'h002, WD = 10'h001;
    logic clock = 1'b0, rst = 1'b1, inst_valid = 1'b0, rd_src_en, rd_dst_en, wr_dst_en, uses_flags;
    logic sets_flags, is_divide, is_load, is_store, is_indexed, is_jump, is_external;
    logic exec_internal = 1'b1, fetch_ready = 1'b1, wb_pending = 1'b0, wb_dual = 1'b0;
    logic mmult_active = 1'b0, host_local_access = 1'b0, div_busy, div_done, load_done, mem_done;
    logic issue_r, stall_r, mmult_wait_r;
    logic [REG_AW-1:0] rd_src, rd_dst, wr_dst, div_dst, load_dst;
    logic [4:0] div_len = 5'h4;
    logic [3:0] mem_lat = 4'h1;
    int fails = 0, checks = 0, k;
    rpi_interlock rpi_interlock_i (.*);
    rpi_far rpi_far_i (.*);
    initial forever #2.5 clock = ~clock;
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // Presents one instruction and counts the wait ticks until it issues
    task automatic ins(input logic [9:0] a, input logic [5:0] s, input logic [5:0] d, input int lo, input int hi);
        int w;
        w = 0;
        {uses_flags, sets_flags, is_divide, is_load, is_store, is_indexed, is_jump, is_external} = a[9:2];
        {rd_src_en, wr_dst_en, rd_dst_en, rd_src, rd_dst, wr_dst, inst_valid} = {a[1:0], a[1], s, s, d, 1'b1};
        @(negedge clock);
        while (issue_r !== 1'b1 && w < 200) begin
            chk(stall_r, "stall flag low");
            w++;
            @(negedge clock);
        end
        chk(w >= lo && w <= hi, $sformatf("%0d waits, want %0d..%0d", w, lo, hi));
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    initial begin
        k = $urandom(32'hF916C190);
        repeat (6) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        repeat (24) ins(RS | WD, 6'($urandom_range(63, 32)), 6'($urandom_range(31)), 0, 0);
        k = $urandom_range(31);
        ins(RS | WD, 6'h20, 6'(k), 0, 0);
        ins(RS | WD, 6'(k), 6'h21, 1, 1);
        ins(SF | WD, 6'h22, 6'h01, 0, 0);
        ins(UF | RS | WD, 6'h23, 6'h02, 1, 1);
        for (k = 0; k < 2; k++) begin
            {wb_pending, wb_dual} = k[0] ? 2'h1 : 2'h2;
            fork @(negedge clock) {wb_pending, wb_dual} = 2'h0; join_none
            ins(RS | WD, 6'h24, 6'(k + 3), 1, 1);
        end
        ins(ST | IX | RS, 6'h25, 6'h04, 0, 0);
        ins(RS | WD, 6'h26, 6'h05, IDX_STORE_WAIT, IDX_STORE_WAIT);
        ins(JP, 6'h27, 6'h06, 0, 0);
        ins(RS | WD, 6'h28, 6'h07, JUMP_WAIT, JUMP_WAIT);
        exec_internal = 1'b0;
        k = $urandom_range(6, 2);
        fetch_ready = 1'b0;
        fork #(5 * k) fetch_ready = 1'b1; join_none
        ins(RS | WD, 6'h29, 6'h08, k, k + 1);
        div_len = 5'($urandom_range(DIV_MAX_TICKS, 2));
        ins(DV | WD, 6'h2A, 6'h09, 0, 0);
        ins(DV | WD, 6'h2B, 6'h0A, 1, DIV_MAX_TICKS);
        ins(RS | WD, 6'h0A, 6'h0B, 1, DIV_MAX_TICKS);
        mem_lat = 4'h8;
        for (k = 0; k < 3; k++) ins(LD | EX | WD, 6'h2C, 6'(k + 12), k / 2, k / 2 * 12);
        ins(RS | WD, 6'h0E, 6'h10, 1, 12);
        inst_valid = 1'b0;
        mem_lat = 4'h1;
        repeat (12) @(negedge clock);
        ins(LD | WD, 6'h2D, 6'h11, 0, 0);
        ins(RS | WD, 6'h11, 6'h12, 1, 1);
        for (k = 0; k < 4; k++) begin
            {mmult_active, host_local_access} = 2'(k);
            @(negedge clock);
            chk(mmult_wait_r === (k == 3), "multiply wait");
        end
        give_verdict();
    end
endmodule
